// ===== design/acsd_pkg.sv
/*
  acsd_pkg: shared constants for the command decoder and security/SMART dispatcher.
  Assumes: one 100 MHz clock domain, task-file bytes presented by the shadow register logic.
*/
package acsd_pkg;
  // command codes
  localparam logic [7:0] CMD_DEVCFG        = 8'hb1;
  localparam logic [7:0] CMD_NATIVE_MAX    = 8'hf8;
  localparam logic [7:0] CMD_NATIVE_MAX_X  = 8'h27;
  localparam logic [7:0] CMD_SET_MAX_X     = 8'h37;
  localparam logic [7:0] CMD_MAX_FAMILY    = 8'hf9;
  localparam logic [7:0] CMD_VERIFY_R      = 8'h40;
  localparam logic [7:0] CMD_VERIFY_NR     = 8'h41;
  localparam logic [7:0] CMD_VERIFY_X      = 8'h42;
  localparam logic [7:0] CMD_RD_DMA_R      = 8'hc8;
  localparam logic [7:0] CMD_RD_DMA_NR     = 8'hc9;
  localparam logic [7:0] CMD_RD_DMA_X      = 8'h25;
  localparam logic [7:0] CMD_WR_DMA_R      = 8'hca;
  localparam logic [7:0] CMD_WR_DMA_X      = 8'h35;
  localparam logic [7:0] CMD_SMART         = 8'hb0;
  localparam logic [7:0] CMD_SEC_SET_PW    = 8'hf1;
  localparam logic [7:0] CMD_SEC_UNLOCK    = 8'hf2;
  localparam logic [7:0] CMD_SEC_ERASE     = 8'hf4;
  // device configuration subcodes
  localparam logic [7:0] DCFG_RESTORE      = 8'hc0;
  localparam logic [7:0] DCFG_SET          = 8'hc3;
  // max-address family subcodes
  localparam logic [7:0] MAX_FREEZE        = 8'h04;
  // smart subcodes
  localparam logic [7:0] SM_READ_DATA      = 8'hd0;
  localparam logic [7:0] SM_READ_THRESH    = 8'hd1;
  localparam logic [7:0] SM_LAST_LOW       = 8'hd6;
  localparam logic [7:0] SM_FIRST_HIGH     = 8'hd8;
  localparam logic [7:0] SM_AUTO_OFFLINE   = 8'hdb;
  // password and transfer sizes
  localparam logic [7:0] PW_FILL_BYTE      = 8'h20;
  localparam int         PW_BYTES          = 32;
  localparam int         SECTOR_BYTES      = 512;
  localparam logic [9:0] SECTOR_LAST       = 10'h1ff;
  // dispatch class codes seen on o_dispatch_class
  localparam logic [3:0] CLS_NONE          = 4'h0;
  localparam logic [3:0] CLS_DEVCFG        = 4'h1;
  localparam logic [3:0] CLS_NATIVE_MAX    = 4'h2;
  localparam logic [3:0] CLS_SET_MAX_X     = 4'h3;
  localparam logic [3:0] CLS_MAX_FAMILY    = 4'h4;
  localparam logic [3:0] CLS_VERIFY        = 4'h5;
  localparam logic [3:0] CLS_RD_DMA        = 4'h6;
  localparam logic [3:0] CLS_WR_DMA        = 4'h7;
  localparam logic [3:0] CLS_SMART         = 4'h8;
  localparam logic [3:0] CLS_SECURITY      = 4'h9;
  // sequencer states
  typedef enum logic [2:0]
  {
    ST_IDLE   = 3'b000,
    ST_BUSY   = 3'b001,
    ST_SAVE   = 3'b010,
    ST_FETCH  = 3'b011,
    ST_DRQ    = 3'b100,
    ST_XFER   = 3'b101,
    ST_DONE   = 3'b110
  } acsd_state_t;
endpackage

// ===== design/acsd_security.sv
/*
  acsd_security: password store and lock state.
  Assumes: the caller asserts i_pw_valid with one 32-byte password at a time, and
  i_power_on pulses once per power-on event (not on software reset).
*/
`timescale 1ns/1ps
module acsd_security
(
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_rstn,
  input  wire logic                          i_factory,
  input  wire logic                          i_power_on,
  input  wire logic                          i_set_pw,
  input  wire logic                          i_pw_is_master,
  input  wire logic                          i_level_max,
  input  wire logic                          i_unlock,
  input  wire logic                          i_erase,
  input  wire logic [8*acsd_pkg::PW_BYTES-1:0] i_pw,
  output logic                               o_locked,
  output logic                               o_user_set,
  output logic                               o_level_max,
  output logic                               o_grant,
  output logic                               o_erase_all
);
  logic [8*acsd_pkg::PW_BYTES-1:0] master_reg;
  logic [8*acsd_pkg::PW_BYTES-1:0] user_reg;
  logic                            user_set_reg;
  logic                            locked_reg;
  logic                            level_max_reg;
  logic [8*acsd_pkg::PW_BYTES-1:0] fill_w;
  wire                             match_master = (i_pw == master_reg);
  wire                             match_user   = user_set_reg && (i_pw == user_reg);
  // master may only unlock at high level; at max level only erase with master works
  wire                             unlock_ok    = i_unlock && (match_user || (match_master && !level_max_reg));
  wire                             erase_ok     = i_erase && match_master;

  genvar g;
  generate
    for (g = 0; g < acsd_pkg::PW_BYTES; g++)
    begin : g_fill
      assign fill_w[8*g +: 8] = acsd_pkg::PW_FILL_BYTE;
    end
  endgenerate

  assign o_locked    = locked_reg;
  assign o_user_set  = user_set_reg;
  assign o_level_max = level_max_reg;
  assign o_grant     = unlock_ok || (erase_ok && locked_reg);
  assign o_erase_all = erase_ok;

  // password store; factory default is blanks with lock function off
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      master_reg    <= '0;
      user_reg      <= '0;
      user_set_reg  <= 1'b0;
      level_max_reg <= 1'b0;
    end
    else if (i_factory)
    begin
      master_reg    <= fill_w;
      user_set_reg  <= 1'b0;
      level_max_reg <= 1'b0;
    end
    else if (i_set_pw && i_pw_is_master)
      master_reg <= i_pw;
    else if (i_set_pw)
    begin
      user_reg      <= i_pw;
      user_set_reg  <= 1'b1;
      level_max_reg <= i_level_max;
    end
    else if (erase_ok)
      user_set_reg <= 1'b0; // erase drops the user password too
  end

  // lock takes effect only at power-on, never at the moment the password is stored
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      locked_reg <= 1'b0;
    else if (i_factory || unlock_ok || erase_ok)
      locked_reg <= 1'b0;
    else if (i_power_on)
      locked_reg <= user_set_reg;
  end
endmodule

// ===== design/acsd_dispatch.sv
/*
  acsd_dispatch: task-file command decoder with security gating and SMART dispatch,
  including the read-data and read-thresholds sequences toward the host.
  Assumes: shadow register logic gives a one-cycle i_cmd_wr with the command byte and
  the already loaded features byte; i_status_rd pulses on each host status read;
  i_data_rd pulses once per byte taken from the data register; the attribute back end
  answers i_save_done and i_fetch_done as pulses.
*/
// Contract
// - B1h with subcode C0h..C3h decodes as device configuration.
// - F8h and 27h read native max address; 37h sets extended max.
// - F9h is the max-address family, subcodes 00h through 04h.
// - 40h, 41h, 42h decode as verify commands, no data to host.
// - C8h, C9h, 25h read DMA; CAh, 35h write DMA.
// - Factory state: master password all 20h, lock function off.
// - Setting master password never enables the lock.
// - Stored user password locks the drive at next power-on only.
// - Locked drive refuses media access until unlock succeeds.
// - High level: master password unlocks.
// - Max level: only erase with master password unlocks, erasing data.
// - SMART subcodes D0h..D6h, D8h..DBh map to their subcommands.
// - Read data: busy, save, data request, clear busy, interrupt, 512 bytes.
// - Read thresholds: fetch sectors, then wait for 512 bytes taken.
// - Execution starts on command write using loaded registers.
// - Status read clears the pending interrupt.
// - Refused command sets the abort bit.
`timescale 1ns/1ps
module acsd_dispatch
(
  input  wire logic                            i_clk_sys,
  input  wire logic                            i_rstn,
  input  wire logic                            i_cmd_wr,
  input  wire logic [7:0]                      i_cmd,
  input  wire logic [7:0]                      i_features,
  input  wire logic                            i_status_rd,
  input  wire logic                            i_data_rd,
  input  wire logic                            i_save_done,
  input  wire logic                            i_fetch_done,
  input  wire logic                            i_factory,
  input  wire logic                            i_power_on,
  input  wire logic                            i_pw_valid,
  input  wire logic                            i_pw_is_master,
  input  wire logic                            i_level_max,
  input  wire logic [8*acsd_pkg::PW_BYTES-1:0] i_pw,
  output logic                                 o_bsy,
  output logic                                 o_drq,
  output logic                                 o_err,
  output logic                                 o_abrt,
  output logic                                 o_intrq,
  output logic [3:0]                           o_dispatch_class,
  output logic [7:0]                           o_subcode,
  output logic                                 o_dispatch,
  output logic                                 o_save_req,
  output logic                                 o_fetch_req,
  output logic [9:0]                           o_byte_index,
  output logic                                 o_locked,
  output logic                                 o_erase_all
);
  acsd_pkg::acsd_state_t state_reg;
  acsd_pkg::acsd_state_t state_next;
  logic       bsy_reg;
  logic       drq_reg;
  logic       err_reg;
  logic       abrt_reg;
  logic       intrq_reg;
  logic [3:0] class_reg;
  logic [7:0] sub_reg;
  logic       dispatch_reg;
  logic       is_thresh_reg;
  logic [9:0] cnt_reg;
  logic       locked_w;
  logic       grant_w;
  logic       refuse_pend;
  logic       rd_pend;
  logic       thr_pend;

  // decode of the command byte together with the features byte, taken at the write
  wire is_devcfg   = (i_cmd == acsd_pkg::CMD_DEVCFG)
                   && (i_features >= acsd_pkg::DCFG_RESTORE) && (i_features <= acsd_pkg::DCFG_SET);
  wire is_natmax   = (i_cmd == acsd_pkg::CMD_NATIVE_MAX) || (i_cmd == acsd_pkg::CMD_NATIVE_MAX_X);
  wire is_setmaxx  = (i_cmd == acsd_pkg::CMD_SET_MAX_X);
  wire is_maxfam   = (i_cmd == acsd_pkg::CMD_MAX_FAMILY) && (i_features <= acsd_pkg::MAX_FREEZE);
  wire is_verify   = (i_cmd == acsd_pkg::CMD_VERIFY_R) || (i_cmd == acsd_pkg::CMD_VERIFY_NR)
                   || (i_cmd == acsd_pkg::CMD_VERIFY_X);
  wire is_rd_dma   = (i_cmd == acsd_pkg::CMD_RD_DMA_R) || (i_cmd == acsd_pkg::CMD_RD_DMA_NR)
                   || (i_cmd == acsd_pkg::CMD_RD_DMA_X);
  wire is_wr_dma   = (i_cmd == acsd_pkg::CMD_WR_DMA_R) || (i_cmd == acsd_pkg::CMD_WR_DMA_X);
  // subcode comes only from features, loaded before the command byte
  wire sm_low      = (i_features >= acsd_pkg::SM_READ_DATA) && (i_features <= acsd_pkg::SM_LAST_LOW);
  wire sm_high     = (i_features >= acsd_pkg::SM_FIRST_HIGH) && (i_features <= acsd_pkg::SM_AUTO_OFFLINE);
  wire is_smart    = (i_cmd == acsd_pkg::CMD_SMART) && (sm_low || sm_high);
  wire is_sm_read  = is_smart && (i_features == acsd_pkg::SM_READ_DATA);
  wire is_sm_thr   = is_smart && (i_features == acsd_pkg::SM_READ_THRESH);
  wire is_set_pw   = (i_cmd == acsd_pkg::CMD_SEC_SET_PW);
  wire is_unlock   = (i_cmd == acsd_pkg::CMD_SEC_UNLOCK);
  wire is_erase    = (i_cmd == acsd_pkg::CMD_SEC_ERASE);
  wire is_security = is_set_pw || is_unlock || is_erase;
  wire is_media    = is_verify || is_rd_dma || is_wr_dma;
  wire is_known    = is_devcfg || is_natmax || is_setmaxx || is_maxfam || is_media || is_smart || is_security;

  // a new command is only taken while idle; the host must not write during busy or drq
  wire take        = i_cmd_wr && (state_reg == acsd_pkg::ST_IDLE);
  wire lock_refuse = take && is_media && locked_w;
  // unlock with a wrong password, or set password while locked, is refused
  wire sec_refuse  = take && ((is_unlock && !grant_w) || (is_set_pw && locked_w)
                   || (is_erase && !i_pw_valid) || (is_unlock && !i_pw_valid));
  wire refuse      = take && (!is_known || lock_refuse || sec_refuse);
  wire start_rd    = take && !refuse && is_sm_read;
  wire start_thr   = take && !refuse && is_sm_thr;
  wire sec_go      = take && !refuse && i_pw_valid;
  wire xfer_last   = (cnt_reg == acsd_pkg::SECTOR_LAST) && i_data_rd;
  wire finish      = (state_reg == acsd_pkg::ST_DONE);

  wire [3:0] class_w = is_devcfg  ? acsd_pkg::CLS_DEVCFG     :
                       is_natmax  ? acsd_pkg::CLS_NATIVE_MAX :
                       is_setmaxx ? acsd_pkg::CLS_SET_MAX_X  :
                       is_maxfam  ? acsd_pkg::CLS_MAX_FAMILY :
                       is_verify  ? acsd_pkg::CLS_VERIFY     :
                       is_rd_dma  ? acsd_pkg::CLS_RD_DMA     :
                       is_wr_dma  ? acsd_pkg::CLS_WR_DMA     :
                       is_smart   ? acsd_pkg::CLS_SMART      :
                       is_security ? acsd_pkg::CLS_SECURITY  : acsd_pkg::CLS_NONE;

  acsd_security u_security
  (
    .i_clk_sys      (i_clk_sys),
    .i_rstn         (i_rstn),
    .i_factory      (i_factory),
    .i_power_on     (i_power_on),
    .i_set_pw       (sec_go && is_set_pw),
    .i_pw_is_master (i_pw_is_master),
    .i_level_max    (i_level_max),
    .i_unlock       (take && is_unlock && i_pw_valid),
    .i_erase        (take && is_erase && i_pw_valid),
    .i_pw           (i_pw),
    .o_locked       (locked_w),
    .o_user_set     (),
    .o_level_max    (),
    .o_grant        (grant_w),
    .o_erase_all    (o_erase_all)
  );

  // sequencer for the two SMART transfers; other commands finish after one busy cycle
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      acsd_pkg::ST_IDLE:  if (take) state_next = acsd_pkg::ST_BUSY;
      acsd_pkg::ST_BUSY:
        if (refuse_pend)   state_next = acsd_pkg::ST_DONE;
        else if (rd_pend)  state_next = acsd_pkg::ST_SAVE;
        else if (thr_pend) state_next = acsd_pkg::ST_FETCH;
        else               state_next = acsd_pkg::ST_DONE;
      acsd_pkg::ST_SAVE:  if (i_save_done) state_next = acsd_pkg::ST_DRQ;
      acsd_pkg::ST_FETCH: if (i_fetch_done) state_next = acsd_pkg::ST_DRQ;
      acsd_pkg::ST_DRQ:   state_next = acsd_pkg::ST_XFER;
      acsd_pkg::ST_XFER:  if (xfer_last) state_next = acsd_pkg::ST_IDLE;
      acsd_pkg::ST_DONE:  state_next = acsd_pkg::ST_IDLE;
      default:            state_next = acsd_pkg::ST_IDLE;
    endcase
  end

  // command latch: what was decided at the write is held until the command ends
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      refuse_pend <= 1'b0;
      rd_pend     <= 1'b0;
      thr_pend    <= 1'b0;
      class_reg   <= acsd_pkg::CLS_NONE;
      sub_reg     <= 8'h00;
    end
    else if (take)
    begin
      refuse_pend <= refuse;
      rd_pend     <= start_rd;
      thr_pend    <= start_thr;
      class_reg   <= class_w;
      sub_reg     <= i_features;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      state_reg <= acsd_pkg::ST_IDLE;
    else
      state_reg <= state_next;
  end

  // busy rises on the write and falls in the cycle drq rises, so the order holds
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      bsy_reg <= 1'b0;
      drq_reg <= 1'b0;
    end
    else
    begin
      bsy_reg <= (state_next == acsd_pkg::ST_BUSY) || (state_next == acsd_pkg::ST_SAVE)
              || (state_next == acsd_pkg::ST_FETCH);
      drq_reg <= (state_next == acsd_pkg::ST_DRQ) || (state_next == acsd_pkg::ST_XFER);
    end
  end

  // error and abort: cleared when the next command arrives, set on refusal at the end
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      err_reg  <= 1'b0;
      abrt_reg <= 1'b0;
    end
    else if (take)
    begin
      err_reg  <= 1'b0;
      abrt_reg <= 1'b0;
    end
    else if (finish && refuse_pend)
    begin
      err_reg  <= 1'b1;
      abrt_reg <= 1'b1;
    end
  end

  // interrupt: raised one cycle after busy clears; a raise in the same cycle as a
  // status read wins, so a completing command is never lost
  wire intr_set = finish || (state_reg == acsd_pkg::ST_DRQ);
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      intrq_reg <= 1'b0;
    else if (intr_set)
      intrq_reg <= 1'b1;
    else if (i_status_rd)
      intrq_reg <= 1'b0;
  end

  // byte counter of the 512-byte sector; no bytes are ever offered for refused commands
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      cnt_reg <= 10'h000;
    else if (state_reg == acsd_pkg::ST_DRQ)
      cnt_reg <= 10'h000;
    else if ((state_reg == acsd_pkg::ST_XFER) && i_data_rd)
      cnt_reg <= cnt_reg + 10'h001;
  end

  // one-cycle dispatch pulse to the back end for every accepted command, the two SMART transfers included
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      dispatch_reg <= 1'b0;
    else
      dispatch_reg <= take && !refuse;
  end

  assign o_bsy            = bsy_reg;
  assign o_drq            = drq_reg;
  assign o_err            = err_reg;
  assign o_abrt           = abrt_reg;
  assign o_intrq          = intrq_reg;
  assign o_dispatch_class = class_reg;
  assign o_subcode        = sub_reg;
  assign o_dispatch       = dispatch_reg;
  assign o_save_req       = (state_reg == acsd_pkg::ST_SAVE);
  assign o_fetch_req      = (state_reg == acsd_pkg::ST_FETCH);
  assign o_byte_index     = cnt_reg;
  assign o_locked         = locked_w;
endmodule

// ===== testbench/acsd_checker_assertions.sv
/*
  acsd_checker: concurrent checks on the ports of acsd_dispatch, bound in below.
  Assumes: one clock, active-low asynchronous reset, one-cycle pulses on the strobes.
*/
`timescale 1ns/1ps
module acsd_checker
(
  input wire logic       i_clk_sys,
  input wire logic       i_rstn,
  input wire logic       i_cmd_wr,
  input wire logic       i_status_rd,
  input wire logic       i_data_rd,
  input wire logic       i_save_done,
  input wire logic       i_fetch_done,
  input wire logic       i_power_on,
  input wire logic       o_bsy,
  input wire logic       o_drq,
  input wire logic       o_err,
  input wire logic       o_abrt,
  input wire logic       o_intrq,
  input wire logic [7:0] o_subcode,
  input wire logic       o_dispatch,
  input wire logic       o_locked,
  input wire logic       o_erase_all
);
  logic [10:0] rd_cnt_reg;

  // bytes taken in the running transfer; a counter keeps the length check cheap
  always_ff @(posedge i_clk_sys or negedge i_rstn)
    if (!i_rstn)
      rd_cnt_reg <= 11'h000;
    else
      rd_cnt_reg <= o_drq ? rd_cnt_reg + {10'h000, i_data_rd} : 11'h000;

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  a_take_raises_busy: assert property ($rose(o_bsy) |-> $past(i_cmd_wr))
    else $error("busy rose without a command write");
  a_dispatch_while_busy: assert property (o_dispatch |-> o_bsy)
    else $error("dispatch outside the busy phase");
  a_drq_order: assert property ($rose(o_drq) |-> $fell(o_bsy) ##1 o_intrq)
    else $error("data request, busy clear and interrupt out of order");
  a_save_before_drq: assert property ($rose(o_drq) && o_subcode == 8'hd0 |-> $past(i_save_done))
    else $error("data request before attributes were saved");
  a_fetch_before_drq: assert property ($rose(o_drq) && o_subcode == 8'hd1 |-> $past(i_fetch_done))
    else $error("data request before thresholds were fetched");
  a_status_read_clears: assert property (o_intrq && i_status_rd && !o_bsy |=> !o_intrq)
    else $error("status read left the interrupt pending");
  a_transfer_length: assert property ($fell(o_drq) |-> rd_cnt_reg == 11'h200)
    else $error("transfer ended with a wrong byte count");
  a_abort_no_data: assert property (o_abrt |-> !o_drq)
    else $error("data request on an aborted command");
  a_error_complete: assert property ($rose(o_err) |-> o_abrt && o_intrq)
    else $error("error without abort and interrupt");
  a_lock_at_power_on: assert property ($rose(o_locked) |-> $past(i_power_on))
    else $error("lock engaged without a power-on event");
  a_erase_unlocks: assert property (o_erase_all |=> !o_locked)
    else $error("erase unit left the drive locked");
endmodule

bind acsd_dispatch acsd_checker acsd_checker_i (.i_clk_sys, .i_rstn, .i_cmd_wr, .i_status_rd, .i_data_rd,
  .i_save_done, .i_fetch_done, .i_power_on, .o_bsy, .o_drq, .o_err, .o_abrt, .o_intrq, .o_subcode,
  .o_dispatch, .o_locked, .o_erase_all);

// ===== testbench/acsd_host_model.sv
/*
  acsd_host_model: behavioural host plus attribute back end facing the dispatcher.
  Assumes: everything changes on the falling edge; i_slow stretches the save and fetch answers and spaces the data reads, not the status read.
*/
`timescale 1ns/1ps
module acsd_host_model
(
  input  wire logic i_clk_sys,
  input  wire logic i_rstn,
  input  wire logic i_slow,
  input  wire logic i_intrq,
  input  wire logic i_drq,
  input  wire logic i_save_req,
  input  wire logic i_fetch_req,
  output logic      o_status_rd,
  output logic      o_data_rd,
  output logic      o_save_done,
  output logic      o_fetch_done
);
  logic       [4:0] wait_reg;
  logic       [1:0] int_age_reg;
  logic       [1:0] gap_reg;
  logic             got_int_reg;
  wire  logic [4:0] lim = i_slow ? 5'h14 : 5'h01;

  // reads only after the interrupt, one byte per pulse, never two pulses back to back
  always @(negedge i_clk_sys or negedge i_rstn)
    if (!i_rstn)
    begin
      wait_reg     <= 5'h00;
      int_age_reg  <= 2'h0;
      gap_reg      <= 2'h0;
      got_int_reg  <= 1'b0;
      o_status_rd  <= 1'b0;
      o_data_rd    <= 1'b0;
      o_save_done  <= 1'b0;
      o_fetch_done <= 1'b0;
    end
    else
    begin
      wait_reg     <= (i_save_req | i_fetch_req) ? wait_reg + 5'h01 : 5'h00;
      o_save_done  <= i_save_req && wait_reg == lim;
      o_fetch_done <= i_fetch_req && wait_reg == lim;
      int_age_reg  <= i_intrq ? int_age_reg + 2'h1 : 2'h0;
      o_status_rd  <= int_age_reg == 2'h2;
      got_int_reg  <= i_drq & (got_int_reg | i_intrq);
      gap_reg      <= gap_reg + 2'h1;
      o_data_rd    <= got_int_reg && i_drq && !o_data_rd && (!i_slow || gap_reg == 2'h0);
    end
endmodule

// ===== testbench/tb.sv
/*
  tb: self-checking bench for acsd_dispatch with the behavioural host beside it.
  Assumes: inputs change on the falling edge; the checker is bound in from its own file.
*/
`timescale 1ns/1ps
module tb;
  logic         i_clk_sys = 1'b0;
  logic         i_rstn = 1'b0;
  logic         i_cmd_wr = 1'b0;
  logic [7:0]   i_cmd = 8'h00;
  logic [7:0]   i_features = 8'h00;
  logic         i_factory = 1'b0;
  logic         i_power_on = 1'b0;
  logic         i_pw_valid = 1'b0;
  logic         i_pw_is_master = 1'b0;
  logic         i_level_max = 1'b0;
  logic [255:0] i_pw = 256'h0;
  logic         slow = 1'b0;
  logic         i_status_rd, i_data_rd, i_save_done, i_fetch_done;
  logic         o_bsy, o_drq, o_err, o_abrt, o_intrq, o_dispatch, o_save_req, o_fetch_req, o_locked, o_erase_all;
  logic [3:0]   o_dispatch_class;
  logic [7:0]   o_subcode;
  logic [9:0]   o_byte_index;
  logic [255:0] upw, mpw;
  logic [4:0]   exp_q[$];
  logic [4:0]   e;
  logic         intrq_q = 1'b0, drq_q = 1'b0;
  integer       seed = 32'h4af7;
  integer       miscompares = 0, num_checks = 0, nbytes = 0, erasures = 0;
  // command code and expected class of the plain commands
  logic [11:0]  plain [11] = '{12'hf82, 12'h272, 12'h373, 12'h405, 12'h415, 12'h425, 12'hc86, 12'hc96, 12'h256,
                             12'hca7, 12'h357};

  always #5 i_clk_sys = ~i_clk_sys;

  acsd_dispatch acsd_dispatch_i (.i_clk_sys, .i_rstn, .i_cmd_wr, .i_cmd, .i_features, .i_status_rd, .i_data_rd,
    .i_save_done, .i_fetch_done, .i_factory, .i_power_on, .i_pw_valid, .i_pw_is_master, .i_level_max, .i_pw,
    .o_bsy, .o_drq, .o_err, .o_abrt, .o_intrq, .o_dispatch_class, .o_subcode, .o_dispatch, .o_save_req,
    .o_fetch_req, .o_byte_index, .o_locked, .o_erase_all);
  acsd_host_model acsd_host_model_i (.i_clk_sys, .i_rstn, .i_slow(slow), .i_intrq(o_intrq), .i_drq(o_drq),
    .i_save_req(o_save_req), .i_fetch_req(o_fetch_req), .o_status_rd(i_status_rd), .o_data_rd(i_data_rd),
    .o_save_done(i_save_done), .o_fetch_done(i_fetch_done));

  task automatic check(input string name, input logic [9:0] exp, input logic [9:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // features go out with the command byte, so the subcode is loaded before the take
  task automatic issue(input logic [7:0] c, input logic [7:0] f, input logic err, input logic [3:0] cls);
    integer n;
    exp_q.push_back({err, cls});
    i_cmd = c;
    i_features = f;
    i_cmd_wr = 1'b1;
    @(negedge i_clk_sys);
    i_cmd_wr = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    n = 0;
    while ((o_bsy | o_drq | o_intrq) !== 1'b0 && n < 5000)
    begin
      @(negedge i_clk_sys);
      n++;
    end
    if (n == 5000)
      check("completion", 10'h1, 10'h0);
  endtask

  task automatic setpw(input logic [255:0] p, input logic m, input logic lv);
    i_pw = p;
    i_pw_valid = 1'b1;
    i_pw_is_master = m;
    i_level_max = lv;
  endtask

  task automatic power_up(input logic exp_lock);
    i_power_on = 1'b1;
    @(negedge i_clk_sys);
    i_power_on = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    check("locked", {9'h0, exp_lock}, {9'h0, o_locked});
  endtask

  task automatic results;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // oldest expectation is taken off the queue on each new interrupt
  always @(negedge i_clk_sys)
  begin
    if (o_intrq && !intrq_q && exp_q.size() == 0)
      check("queue", 10'h1, 10'h0);
    else if (o_intrq && !intrq_q)
    begin
      e = exp_q.pop_front();
      check("error", {9'h0, e[4]}, {9'h0, o_err});
      check("abort", {9'h0, e[4]}, {9'h0, o_abrt});
      if (!e[4])
        check("class", {6'h0, e[3:0]}, {6'h0, o_dispatch_class});
    end
    if (!drq_q && o_drq)
      nbytes = 0;
    nbytes = nbytes + i_data_rd;
    if (drq_q && !o_drq)
      check("bytes", 10'h200, nbytes[9:0]);
    if (drq_q && o_drq)
      check("index", nbytes[9:0], o_byte_index);
    intrq_q = o_intrq;
    drq_q = o_drq;
  end

  // the erase strobe is combinational, so it is counted where inputs are settled
  always @(posedge i_clk_sys)
    if (o_erase_all)
      erasures++;

  initial
  begin
    #300000;
    miscompares++;
    results();
  end

  initial
  begin
    repeat (16) @(negedge i_clk_sys);
    i_rstn = 1'b1;
    check("reset", 10'h0, {6'h0, o_bsy, o_drq, o_intrq, o_locked});
    i_factory = 1'b1;
    @(negedge i_clk_sys);
    i_factory = 1'b0;
    foreach (plain[k])
      issue(plain[k][11:4], 8'($random(seed)), 1'b0, plain[k][3:0]);
    for (int s = 8'hc0; s <= 8'hc4; s++)
      issue(8'hb1, s[7:0], s == 8'hc4, 4'h1);
    for (int s = 0; s <= 5; s++)
      issue(8'hf9, s[7:0], s == 5, 4'h4);
    for (int s = 8'hd2; s <= 8'hdc; s++)
      issue(8'hb0, s[7:0], s == 8'hd7 || s == 8'hdc, 4'h8);
    issue(8'hb0, 8'hcf, 1'b1, 4'h8);
    issue(8'h00, 8'h00, 1'b1, 4'h0);
    issue(8'hb0, 8'hd0, 1'b0, 4'h8);
    slow = 1'b1;
    issue(8'hb0, 8'hd1, 1'b0, 4'h8);
    issue(8'hb0, 8'hd0, 1'b0, 4'h8);
    slow = 1'b0;
    // user password at high level, then the blank master password unlocks
    upw = {8{$random(seed)}};
    mpw = {8{$random(seed)}};
    setpw(upw, 1'b0, 1'b0);
    issue(8'hf1, 8'h00, 1'b0, 4'h9);
    power_up(1'b1);
    issue(8'hc8, 8'h00, 1'b1, 4'h6);
    issue(8'hf1, 8'h00, 1'b1, 4'h9);
    setpw(~upw, 1'b0, 1'b0);
    issue(8'hf2, 8'h00, 1'b1, 4'h9);
    setpw({32{8'h20}}, 1'b1, 1'b0);
    issue(8'hf2, 8'h00, 1'b0, 4'h9);
    issue(8'hc8, 8'h00, 1'b0, 4'h6);
    // new master password alone never locks; maximum level needs the erase
    i_factory = 1'b1;
    @(negedge i_clk_sys);
    i_factory = 1'b0;
    setpw(mpw, 1'b1, 1'b0);
    issue(8'hf1, 8'h00, 1'b0, 4'h9);
    power_up(1'b0);
    setpw(upw, 1'b0, 1'b1);
    issue(8'hf1, 8'h00, 1'b0, 4'h9);
    power_up(1'b1);
    setpw(mpw, 1'b1, 1'b0);
    issue(8'hf2, 8'h00, 1'b1, 4'h9);
    issue(8'hf4, 8'h00, 1'b0, 4'h9);
    check("erased", 10'h1, erasures[9:0]);
    check("unlocked", 10'h0, {9'h0, o_locked});
    issue(8'h25, 8'h00, 1'b0, 4'h6);
    i_pw_valid = 1'b0;
    issue(8'hf4, 8'h00, 1'b1, 4'h9);
    check("pending", 10'h0, 10'(exp_q.size()));
    results();
  end
endmodule
